// ---- hdl/mts_pkg.sv ----
// package for the melody tone sequencer: register map, field positions,
// reset values, state codes and timing constants.
// assumes a 32-bit APB slave port with one register per aligned word.
package mts_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CLK = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_CTL = 8'h08;
  localparam logic [7:0] ADDR_DAT = 8'h0c;
  localparam logic [7:0] ADDR_FLG = 8'h10;
  localparam logic [7:0] ADDR_IEN = 8'h14;
  localparam logic [7:0] ADDR_DMA = 8'h18;

  // sound_clock_ctrl_reg fields
  localparam int CLK_DBG_BIT = 8;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_SRC_LSB = 0;
  // sound_select_reg fields
  localparam int SEL_TEMPO_LSB = 8;
  localparam int SEL_INV_BIT = 2;
  localparam int SEL_MODE_LSB = 0;
  // sound_control_reg fields
  localparam int CTL_STOP_BIT = 8;
  localparam int CTL_EN_BIT = 0;
  // sound_buffer_reg fields
  localparam int DAT_TIE_BIT = 15;
  localparam int DAT_REST_BIT = 14;
  localparam int DAT_LEN_LSB = 8;
  localparam int DAT_PITCH_LSB = 0;
  // sound_flag_reg / sound_irq_enable_reg fields
  localparam int FLG_BUSY_BIT = 8;
  localparam int FLG_EMPTY_BIT = 1;
  localparam int FLG_DONE_BIT = 0;

  // reset values
  localparam logic [15:0] DAT_RESET = 16'h00ff;
  localparam logic EMPTY_RESET = 1'b1;

  localparam logic [1:0] MODE_MELODY = 2'h2;
  localparam logic [2:0] DIV_RESERVED = 3'h7;
  // divider ratio at code 0 is 16; reserved code 0x7 gives 1
  localparam logic [10:0] DIV_BASE = 11'h010;

  // sound ticks per thirty-second note at the fastest tempo (code 0)
  localparam logic [13:0] UNIT_TICKS_BASE = 14'h0200;
  // silent sound ticks at the head of an untied note
  localparam logic [5:0] ARTIC_TICKS = 6'h10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PLAY = 2'b10
  } mts_state_t;

endpackage

// ---- hdl/mts_tone_gen.sv ----
// tone divider: one period per pitch code plus one sound ticks.
// assumes tick_i is a single-cycle enable in the system clock domain.
`timescale 1ns/1ns
module mts_tone_gen (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic [7:0] pitch_i,
  // tone level
  output logic tone_o
);
  import mts_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [8:0] half;

  always_comb begin
    half = ({1'b0, pitch_i} + 9'h001) >> 1;
    next_cnt = cnt;
    if (restart_i) begin
      next_cnt = 8'h00;
    end else if (tick_i) begin
      // >= keeps a pitch change mid-period from running past the end
      next_cnt = (cnt >= pitch_i) ? 8'h00 : cnt + 8'h01;
    end
    tone_o = {1'b0, cnt} < half;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ---- hdl/mts_note_timer.sv ----
// note length timer: (length code + 1) thirty-second units, each unit
// UNIT_TICKS_BASE * (tempo + 1) sound ticks long.
// assumes start_i and tick_i are single-cycle enables.
`timescale 1ns/1ns
module mts_note_timer (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic [3:0] tempo_i,
  input wire logic [5:0] len_i,
  // status
  output logic done_o,
  output logic head_o
);
  import mts_pkg::*;

  logic [13:0] unit_cnt;
  logic [5:0] len_cnt;
  logic [5:0] len_reg;
  logic [5:0] head_cnt;
  logic [13:0] next_unit_cnt;
  logic [5:0] next_len_cnt;
  logic [5:0] next_len_reg;
  logic [5:0] next_head_cnt;
  logic [13:0] unit_last;
  logic unit_end;

  always_comb begin
    unit_last = ({10'h000, tempo_i} + 14'h0001) * UNIT_TICKS_BASE
                - 14'h0001;
    // tempo may change under a note; >= ends the unit at once
    unit_end = unit_cnt >= unit_last;
    done_o = tick_i && unit_end && (len_cnt == len_reg);
    head_o = head_cnt < ARTIC_TICKS;
    next_unit_cnt = unit_cnt;
    next_len_cnt = len_cnt;
    next_len_reg = len_reg;
    next_head_cnt = head_cnt;
    if (start_i) begin
      next_unit_cnt = 14'h0000;
      next_len_cnt = 6'h00;
      next_len_reg = len_i;
      next_head_cnt = 6'h00;
    end else if (tick_i) begin
      if (head_o) begin
        next_head_cnt = head_cnt + 6'h01;
      end
      if (unit_end) begin
        next_unit_cnt = 14'h0000;
        next_len_cnt = len_cnt + 6'h01;
      end else begin
        next_unit_cnt = unit_cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      unit_cnt <= 14'h0000;
      len_cnt <= 6'h00;
      len_reg <= 6'h00;
      head_cnt <= 6'h00;
    end else begin
      unit_cnt <= next_unit_cnt;
      len_cnt <= next_len_cnt;
      len_reg <= next_len_reg;
      head_cnt <= next_head_cnt;
    end
  end

endmodule

// ---- hdl/mts_top.sv ----
// melody tone sequencer: APB registers, one-deep sound buffer, melody
// sequencing, buzzer pin pair, interrupt and DMA request outputs.
// assumes one system clock; the sound clock is a tick derived inside.
// Operation
// R1: software sets output mode 0x2 and tempo before the first note word.
// R2: a buffer write clears buffer-empty and starts or continues output.
// R3: note trigger moves buffer to active word, sets empty and busy.
// R4: trigger with empty buffer stops output, sets done, clears busy.
// R5: software writes a word, then waits for buffer-empty, until melody ends.
// R6: DMA request per enabled channel while buffer-empty is set.
// R7: host DMA uses halfword basic transfers, source +2, fixed destination.
// R8: length codes 0x0f to 0x00 give half through thirty-second; rest bit.
// R9: a tied note follows the previous one with no gap.
// R10: eight-bit pitch code sets the tone frequency.
// R11: writing one to the stop bit also sets buffer-empty.
// R12: done flag clears on write of one or on a buffer write.
// R13: interrupt only while an enabled flag is set.
// R14: software never enables empty interrupt and DMA request together.
// R15: software clears DMA enable once the DMA transfer ends.
// R16: debug keep bit decides whether the sound clock runs in debug halt.
// R17: during a rest the true pin is low and the inverted pin high.
// R18: tempo code selects 480 down to 30 quarter notes per minute.
// R19: divider code selects 1/16 doubling to 1/1024 at code 0x6.
// R20: DMA enable holds one bit per channel; unimplemented ones do nothing.
// R21: note length is code plus one thirty-second units set by tempo.
// R22: one tone period lasts pitch code plus one sound ticks.
`timescale 1ns/1ns
module mts_top #(
  parameter int OSC_DIV = 95,
  parameter int DMA_CHANNELS = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // system
  input wire logic debug_halt_i,
  // buzzer pins
  output logic buzzer_out_o,
  output logic buzzer_out_n_o,
  // requests
  output logic sound_irq_o,
  output logic [15:0] dma_req_o
);
  import mts_pkg::*;

  localparam int OSC_W = $clog2(OSC_DIV + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

  mts_state_t state, next_state;
  logic [OSC_W-1:0] osc_cnt, next_osc_cnt;
  logic [9:0] div_cnt, next_div_cnt;
  logic dbg_keep, next_dbg_keep;
  logic [2:0] clk_div, next_clk_div;
  logic [1:0] clk_src, next_clk_src;
  logic [3:0] tempo, next_tempo;
  logic out_inv, next_out_inv;
  logic [1:0] out_mode, next_out_mode;
  logic gen_en, next_gen_en;
  logic [15:0] buf_word, next_buf_word;
  logic buf_full, next_buf_full;
  logic [15:0] act_word, next_act_word;
  logic busy_flag, next_busy_flag;
  logic empty_flag, next_empty_flag;
  logic done_flag, next_done_flag;
  logic [1:0] irq_en, next_irq_en;
  logic [15:0] dma_en, next_dma_en;
  logic [31:0] rdata, next_rdata;
  logic buzz, next_buzz;

  logic osc_tick, run, snd_tick;
  logic [10:0] div_mask;
  logic apb_wr, apb_rd_setup, hit;
  logic dat_wr, stop_wr, trig, note_start;
  logic note_done, note_head, tone;
  logic [15:0] dma_impl;

  // channels past DMA_CHANNELS are tied off here, whatever is written
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_dma
      assign dma_impl[g] = (g < DMA_CHANNELS);
      assign dma_req_o[g] = empty_flag & dma_en[g] & dma_impl[g]; // [R6] [R20]
    end
  endgenerate

  assign pready_o = 1'b1;
  assign prdata_o = rdata;
  assign sound_irq_o = (empty_flag & irq_en[FLG_EMPTY_BIT])
                     | (done_flag & irq_en[FLG_DONE_BIT]); // [R13]
  assign buzzer_out_o = buzz;
  assign buzzer_out_n_o = ~buzz;

  // sound clock tick: oscillator prescale then power-of-two divider
  always_comb begin
    hit = (paddr_i == ADDR_CLK) || (paddr_i == ADDR_SEL)
       || (paddr_i == ADDR_CTL) || (paddr_i == ADDR_DAT)
       || (paddr_i == ADDR_FLG) || (paddr_i == ADDR_IEN)
       || (paddr_i == ADDR_DMA);
    pslverr_o = psel_i && penable_i && !hit;
    // debug halt freezes the tick unless the keep bit is set
    run = gen_en && !(debug_halt_i && !dbg_keep); // [R16]
    osc_tick = run && (osc_cnt == OSC_LAST);
    div_mask = (clk_div == DIV_RESERVED) ? 11'h000
             : (DIV_BASE << clk_div) - 11'h001; // [R19]
    snd_tick = osc_tick && ((div_cnt & div_mask[9:0]) == div_mask[9:0]);
    next_osc_cnt = osc_cnt;
    next_div_cnt = div_cnt;
    if (run) begin
      next_osc_cnt = osc_tick ? '0 : osc_cnt + OSC_W'(1);
    end
    if (osc_tick) begin
      next_div_cnt = div_cnt + 10'h001;
    end
  end

  mts_note_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(snd_tick),
    .start_i(note_start),
    .tempo_i(tempo), // [R18]
    .len_i(buf_word[DAT_LEN_LSB +: 6]), // [R8] [R21]
    .done_o(note_done),
    .head_o(note_head)
  );

  mts_tone_gen u_tone (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(snd_tick),
    .restart_i(note_start),
    .pitch_i(act_word[DAT_PITCH_LSB +: 8]), // [R10] [R22]
    .tone_o(tone)
  );

  always_comb begin
    apb_wr = psel_i && penable_i && pwrite_i;
    apb_rd_setup = psel_i && !penable_i && !pwrite_i;
    // byte writes to the buffer are ignored: only full halfwords count
    dat_wr = apb_wr && (paddr_i == ADDR_DAT) && (pstrb_i[1:0] == 2'b11);
    stop_wr = apb_wr && (paddr_i == ADDR_CTL) && pstrb_i[1]
           && pwdata_i[CTL_STOP_BIT];
    trig = snd_tick && (((state == ST_IDLE) && buf_full
           && (out_mode == MODE_MELODY)) || ((state == ST_PLAY) && note_done));
    note_start = trig && buf_full;

    next_state = state;
    next_dbg_keep = dbg_keep;
    next_clk_div = clk_div;
    next_clk_src = clk_src;
    next_tempo = tempo;
    next_out_inv = out_inv;
    next_out_mode = out_mode;
    next_gen_en = gen_en;
    next_buf_word = buf_word;
    next_buf_full = buf_full;
    next_act_word = act_word;
    next_busy_flag = busy_flag;
    next_empty_flag = empty_flag;
    next_done_flag = done_flag;
    next_irq_en = irq_en;
    next_dma_en = dma_en;
    next_rdata = rdata;

    if (apb_wr) begin
      unique case (paddr_i)
        ADDR_CLK: begin
          // clock settings are frozen while the generator is enabled
          if (!gen_en) begin
            if (pstrb_i[1]) next_dbg_keep = pwdata_i[CLK_DBG_BIT];
            if (pstrb_i[0]) next_clk_div = pwdata_i[CLK_DIV_LSB +: 3];
            if (pstrb_i[0]) next_clk_src = pwdata_i[CLK_SRC_LSB +: 2];
          end
        end
        ADDR_SEL: begin
          if (pstrb_i[1]) next_tempo = pwdata_i[SEL_TEMPO_LSB +: 4];
          if (pstrb_i[0]) next_out_inv = pwdata_i[SEL_INV_BIT];
          if (pstrb_i[0]) next_out_mode = pwdata_i[SEL_MODE_LSB +: 2];
        end
        ADDR_CTL: begin
          if (pstrb_i[0]) next_gen_en = pwdata_i[CTL_EN_BIT];
        end
        ADDR_FLG: begin
          if (pstrb_i[0] && pwdata_i[FLG_DONE_BIT]) begin
            next_done_flag = 1'b0; // [R12]
          end
        end
        ADDR_IEN: begin
          if (pstrb_i[0]) next_irq_en = pwdata_i[1:0];
        end
        ADDR_DMA: begin
          if (pstrb_i[0]) next_dma_en[7:0] = pwdata_i[7:0];
          if (pstrb_i[1]) next_dma_en[15:8] = pwdata_i[15:8];
        end
        default: begin
        end
      endcase
    end
    if (dat_wr) begin
      next_done_flag = 1'b0; // [R12]
    end

    // trigger acts after the clears so that a same-cycle set wins
    if (trig) begin
      if (buf_full) begin
        next_act_word = buf_word; // [R3]
        next_buf_full = 1'b0;
        next_empty_flag = 1'b1;
        next_busy_flag = 1'b1;
        next_state = ST_PLAY;
      end else begin
        next_state = ST_IDLE; // [R4]
        next_busy_flag = 1'b0;
        next_done_flag = 1'b1;
      end
    end

    // a word written with the trigger lands in the freed buffer
    if (dat_wr) begin
      next_buf_word = pwdata_i[15:0];
      next_buf_full = 1'b1;
      next_empty_flag = 1'b0; // [R2]
    end

    if (stop_wr) begin
      next_state = ST_IDLE;
      next_buf_full = 1'b0;
      next_busy_flag = 1'b0;
      next_done_flag = 1'b1;
      next_empty_flag = 1'b1; // [R11]
    end

    // read data is captured in the setup cycle
    if (apb_rd_setup) begin
      next_rdata = 32'h0000_0000;
      unique case (paddr_i)
        ADDR_CLK: begin
          next_rdata[CLK_DBG_BIT] = dbg_keep;
          next_rdata[CLK_DIV_LSB +: 3] = clk_div;
          next_rdata[CLK_SRC_LSB +: 2] = clk_src;
        end
        ADDR_SEL: begin
          next_rdata[SEL_TEMPO_LSB +: 4] = tempo;
          next_rdata[SEL_INV_BIT] = out_inv;
          next_rdata[SEL_MODE_LSB +: 2] = out_mode;
        end
        ADDR_CTL: next_rdata[CTL_EN_BIT] = gen_en;
        ADDR_DAT: next_rdata[15:0] = buf_word;
        ADDR_FLG: begin
          next_rdata[FLG_BUSY_BIT] = busy_flag;
          next_rdata[FLG_EMPTY_BIT] = empty_flag;
          next_rdata[FLG_DONE_BIT] = done_flag;
        end
        ADDR_IEN: next_rdata[1:0] = irq_en;
        ADDR_DMA: next_rdata[15:0] = dma_en & dma_impl;
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    // rest holds the true pin low; an untied note starts with a short gap
    next_buzz = (state == ST_PLAY) && !act_word[DAT_REST_BIT] // [R17]
             && tone && !(note_head && !act_word[DAT_TIE_BIT]); // [R9]
    if (next_state != ST_PLAY) begin
      next_buzz = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      osc_cnt <= '0;
      div_cnt <= 10'h000;
      dbg_keep <= 1'b0;
      clk_div <= 3'h0;
      clk_src <= 2'h0;
      tempo <= 4'h0;
      out_inv <= 1'b0;
      out_mode <= 2'h0;
      gen_en <= 1'b0;
      buf_word <= DAT_RESET;
      buf_full <= 1'b0;
      act_word <= DAT_RESET;
      busy_flag <= 1'b0;
      empty_flag <= EMPTY_RESET;
      done_flag <= 1'b0;
      irq_en <= 2'h0;
      dma_en <= 16'h0000;
      rdata <= 32'h0000_0000;
      buzz <= 1'b0;
    end else begin
      state <= next_state;
      osc_cnt <= next_osc_cnt;
      div_cnt <= next_div_cnt;
      dbg_keep <= next_dbg_keep;
      clk_div <= next_clk_div;
      clk_src <= next_clk_src;
      tempo <= next_tempo;
      out_inv <= next_out_inv;
      out_mode <= next_out_mode;
      gen_en <= next_gen_en;
      buf_word <= next_buf_word;
      buf_full <= next_buf_full;
      act_word <= next_act_word;
      busy_flag <= next_busy_flag;
      empty_flag <= next_empty_flag;
      done_flag <= next_done_flag;
      irq_en <= next_irq_en;
      dma_en <= next_dma_en;
      rdata <= next_rdata;
      buzz <= next_buzz;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence seq_load;
    trig && buf_full && !dat_wr && !stop_wr;
  endsequence
  sequence seq_rest_play;
    (state == ST_PLAY && act_word[DAT_REST_BIT]) [*2];
  endsequence

  AST_WR_CLEARS_EMPTY: assert property (dat_wr |=> !empty_flag) // [R2]
    else $error("buffer write left empty flag set");
  AST_TRIG_LOADS: assert property (seq_load |=> empty_flag && busy_flag // [R3]
    && act_word == $past(buf_word) && state == ST_PLAY)
    else $error("trigger did not load the active word");
  AST_TRIG_ENDS: assert property (trig && !buf_full && !stop_wr // [R4]
    |=> done_flag && !busy_flag && state == ST_IDLE)
    else $error("trigger on empty buffer did not end output");
  AST_DMA_REQ: assert property ($rose(empty_flag) // [R6]
    && (dma_en & dma_impl) != 16'h0000 |-> dma_req_o == (dma_en & dma_impl)
    ##1 (!empty_flag || dma_req_o == (dma_en & dma_impl)))
    else $error("dma request missing while buffer empty");
  AST_STOP_SETS_EMPTY: assert property (stop_wr // [R11]
    |=> empty_flag && done_flag && !busy_flag ##1 !busy_flag || trig)
    else $error("stop did not set empty and end output");
  AST_DONE_CLEAR: assert property (done_flag && dat_wr && !trig // [R12]
    |=> !done_flag)
    else $error("buffer write did not clear done flag");
  AST_IRQ_CAUSE: assert property (sound_irq_o // [R13]
    |-> (empty_flag && irq_en[FLG_EMPTY_BIT])
     || (done_flag && irq_en[FLG_DONE_BIT]))
    else $error("interrupt without an enabled flag");
  AST_REST_PINS: assert property (seq_rest_play // [R17]
    |-> !buzzer_out_o && buzzer_out_n_o)
    else $error("buzzer pins active during a rest");
  AST_DEBUG_FREEZE: assert property (debug_halt_i && !dbg_keep // [R16]
    |-> !snd_tick ##1 (osc_cnt == $past(osc_cnt) || !debug_halt_i))
    else $error("sound clock ran in debug halt");

endmodule

// ---- test/mts_buzzer_model.sv ----
// piezo buzzer model: measures the tone period and checks the pin pair.
// assumes both pins settle within one system clock.
`timescale 1ns/1ns
module mts_buzzer_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // buzzer pins
  input wire logic pin_i,
  input wire logic pin_n_i,
  // measurements
  output int period_o,
  output int bad_o
);
  int cnt;
  logic last;
  // period is cycles between rising edges of the true pin
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      last <= 1'b0;
      period_o <= 0;
      bad_o <= 0;
    end else begin
      cnt <= cnt + 1;
      last <= pin_i;
      if (pin_i === 1'b1 && last === 1'b0) begin
        period_o <= cnt + 1;
        cnt <= 0;
      end
      // a piezo across the pair needs them complementary at all times
      if (pin_n_i !== ~pin_i) begin
        bad_o <= bad_o + 1;
      end
    end
  end
endmodule

// ---- test/melody_tone_sequencer_test.sv ----
// self-checking bench for the melody tone sequencer top.
// assumes OSC_DIV=1 and divider 0: one 32nd note at tempo 0 is 8192 clocks.
`timescale 1ns/1ns
module melody_tone_sequencer_test;
  import mts_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0] pstrb_i = 4'hf;
  logic debug_halt_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic buzzer_out_o;
  logic buzzer_out_n_o;
  logic sound_irq_o;
  logic [15:0] dma_req_o;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0 = 0;
  int bz_period;
  int bz_bad;

  mts_top #(.OSC_DIV(1), .DMA_CHANNELS(4)) i_dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .debug_halt_i(debug_halt_i), .buzzer_out_o(buzzer_out_o),
    .buzzer_out_n_o(buzzer_out_n_o), .sound_irq_o(sound_irq_o),
    .dma_req_o(dma_req_o)
  );
  mts_buzzer_model i_buzzer (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pin_i(buzzer_out_o),
    .pin_n_i(buzzer_out_n_o), .period_o(bz_period), .bad_o(bz_bad)
  );

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic wait_until(input int t);
    while (cyc < t) @(posedge sys_clk_i);
  endtask

  task automatic t_reset;
    rdc(ADDR_FLG, 32'h0000_0002);
    rdc(ADDR_DAT, 32'h0000_00ff);
    rdc(ADDR_CLK, 32'h0000_0000);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_melody;
    int i;
    wr_mode: begin
      apb(1'b1, ADDR_SEL, 32'h0000_0002); // tempo 0, melody
    end
    apb(1'b1, ADDR_CLK, 32'h0000_0100);
    // channel 15 is not implemented with four channels
    apb(1'b1, ADDR_DMA, 32'h0000_8008);
    rdc(ADDR_DMA, 32'h0000_0008);
    chk({16'h0000, dma_req_o}, 32'h0000_0008);
    apb(1'b1, ADDR_DAT, 32'h0000_0103);
    @(posedge sys_clk_i);
    chk({16'h0000, dma_req_o}, 32'h0000_0000);
    // only the done interrupt: the empty flag belongs to the DMA here
    apb(1'b1, ADDR_IEN, 32'h0000_0001);
    apb(1'b1, ADDR_CTL, 32'h0000_0001);
    i = 0;
    while (dma_req_o[3] !== 1'b1 && i < 200) begin
      @(posedge sys_clk_i);
      i++;
    end
    t0 = cyc;
    chk({31'h0000_0000, dma_req_o[3]}, 32'h0000_0001);
    rdc(ADDR_FLG, 32'h0000_0102);
    apb(1'b1, ADDR_DAT, 32'h0000_4003);
    wait_until(t0 + 4096);
    chk(32'(bz_period), 32'h0000_0040);
    wait_until(t0 + 20480);
    chk({30'h0, buzzer_out_o, buzzer_out_n_o}, 32'h0000_0001);
    i = 0;
    while (sound_irq_o !== 1'b1 && i < 10000) begin
      @(posedge sys_clk_i);
      i++;
    end
    // two units then one unit, 8192 clocks each
    i = cyc - t0;
    chk(32'(i > 24570 && i < 24583), 32'h0000_0001);
    rdc(ADDR_FLG, 32'h0000_0003);
    apb(1'b1, ADDR_DMA, 32'h0000_0000);
    @(posedge sys_clk_i);
    chk({16'h0000, dma_req_o}, 32'h0000_0000);
    apb(1'b1, ADDR_FLG, 32'h0000_0001);
    @(posedge sys_clk_i);
    chk({31'h0000_0000, sound_irq_o}, 32'h0000_0000);
    rdc(ADDR_FLG, 32'h0000_0002);
    chk(32'(bz_bad), 32'h0000_0000);
    $display("test melody done");
  endtask

  task automatic t_debug_stop;
    apb(1'b1, ADDR_CTL, 32'h0000_0000);
    apb(1'b1, ADDR_CLK, 32'h0000_0000);
    apb(1'b1, ADDR_CTL, 32'h0000_0001);
    // clock settings are locked while enabled
    apb(1'b1, ADDR_CLK, 32'h0000_0100);
    rdc(ADDR_CLK, 32'h0000_0000);
    debug_halt_i <= 1'b1;
    apb(1'b1, ADDR_DAT, 32'h0000_0003);
    repeat (200) @(posedge sys_clk_i);
    rdc(ADDR_FLG, 32'h0000_0000);
    apb(1'b1, ADDR_CTL, 32'h0000_0101);
    apb(1'b0, ADDR_FLG, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    debug_halt_i <= 1'b0;
    $display("test debug and stop done");
  endtask

  task automatic t_tie;
    int i;
    apb(1'b1, ADDR_CTL, 32'h0000_0000);
    apb(1'b1, ADDR_CLK, 32'h0000_0100);
    rdc(ADDR_CLK, 32'h0000_0100);
    apb(1'b1, ADDR_CTL, 32'h0000_0001);
    // keep bit set: the halt must not freeze the sound clock
    debug_halt_i <= 1'b1;
    apb(1'b1, ADDR_DAT, 32'h0000_8003);
    i = 0;
    while (buzzer_out_o !== 1'b1 && i < 400) begin
      @(posedge sys_clk_i);
      i++;
    end
    // an untied note would stay silent for 256 clocks
    chk(32'(i < 32), 32'h0000_0001);
    chk({31'h0000_0000, sound_irq_o}, 32'h0000_0000);
    i = 0;
    while (sound_irq_o !== 1'b1 && i < 10000) begin
      @(posedge sys_clk_i);
      i++;
    end
    // one unit of 8192 clocks, seen two clocks after the load
    chk(32'(i > 8180 && i < 8200), 32'h0000_0001);
    rdc(ADDR_FLG, 32'h0000_0003);
    debug_halt_i <= 1'b0;
    $display("test tie done");
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset;
    t_melody;
    t_debug_stop;
    t_tie;
    tally_and_finish;
  end
endmodule
